// [ec_group_ctrl.sv]
// control logic for one group of two echo cancellers: tone detection and
// release, bypass switching, detector enables, pads, configuration, muting.
// assumes an apb master, tone analysis front ends that flag 2100 hz tone,
// phase reversals and low level per input, narrow band tone on receive, and pcm
// samples presented one per channel with a valid strobe.
//
// Function
// - phase-reversal mode triggers after tone lasts one second with a reversal
// - plain mode triggers after 400 ms of tone, reversal or not
// - detectors on receive and send inputs set status and pull interrupt low
// - status holds until both inputs stay quiet for 400 ms
// - a detector release raises the interrupt like a detection
// - phase-check-disable one selects plain mode, zero selects reversal mode
// - auto bypass moves canceller to bypass on detection, back on release
// - ringing suppress enable turns on the instability detector
// - narrow band tones halt adaptation unless its disable bit is set
// - dc removal on both inputs, bypassed by its disable bit
// - four independent pads, +9 to -12 db in 3 db steps
// - legacy receive bit forces -12 db at receive input over gains
// - normal configuration runs two parallel 64 ms cancellers
// - back-to-back needs the select bit set in both cancellers
// - back-to-back uses first slot only, second slot carries quiet code
// - extended tail bit of the first canceller cascades to 128 ms
// - only first canceller holds extended bit; second slot carries quiet code
// - receive mute quiets filter input and receive output; send mute quiets send
// - quiet code follows the coding: 0000, 80, ff, d5 hex
// - in back-to-back the first canceller mute bits quiet the outputs
// - bypass passes data straight and clears coefficients; host holds a frame
`timescale 1ns/1ns
`include "ec_group_regs.svh"

module ec_group_ctrl #(
    parameter int CLKS_PER_MS = `MS_NS / `CLK_NS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ec_group_pkg::tone_in_s [1:0] tone_in,
    input wire ec_group_pkg::pcm_s [1:0] pcm_in,
    input wire logic pcm_in_valid,
    output ec_group_pkg::pcm_out_s [1:0] pcm_out,
    output logic pcm_out_valid,
    output ec_group_pkg::ec_ctrl_s [1:0] ec_ctrl,
    output ec_group_pkg::cfg_e group_cfg,
    output logic [1:0] tone_detected_flag,
    output logic irq_n
);
    import ec_group_pkg::*;

    state_s s_r;
    state_s s_nxt;

    // ======================================================================
    // address decode
    logic [7:0] idx;
    logic ch;
    logic [4:0] off;
    logic mapped;
    logic in_ch;
    logic setup;
    logic access;

    assign idx = paddr[9:2];
    assign ch = idx[5];
    assign off = idx[4:0];
    assign in_ch = (idx[7:6] == 2'h0) && (off == `IDX_CTRL1 || off == `IDX_CTRL2
        || off == `IDX_STATUS || off == `IDX_GAINS);
    assign mapped = in_ch || (idx == `IDX_CODING);
    assign setup = psel & ~penable;
    assign access = psel & penable;

    // ======================================================================
    // group configuration
    cfg_e cfg;
    logic [15:0] quiet;

    always_comb begin
        if (s_r.ctrl1[0][`C1_BACK_TO_BACK] && s_r.ctrl1[1][`C1_BACK_TO_BACK]) begin
            cfg = cfg_back_to_back;
        end else if (s_r.ctrl1[0][`C1_EXT_TAIL]) begin
            cfg = cfg_extended;
        end else begin
            cfg = cfg_normal;
        end
        case (s_r.coding)
            code_linear: quiet = `QUIET_LINEAR;
            code_sign_mag: quiet = `QUIET_SIGN_MAG;
            code_mulaw: quiet = `QUIET_MULAW;
            code_alaw: quiet = `QUIET_ALAW;
            default: quiet = `QUIET_LINEAR;
        endcase
    end

    // ======================================================================
    // per canceller control outputs
    logic [1:0] byp;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            // auto bypass follows the detected status both ways
            byp[c] = s_r.ctrl1[c][`C1_BYPASS]
                | (s_r.ctrl2[c][`C2_AUTO_BYPASS] & s_r.td[c]);
            ec_ctrl[c].bypass = byp[c];
            ec_ctrl[c].coef_clear = byp[c];
            ec_ctrl[c].adapt_halt = s_r.ctrl1[c][`C1_ADAPT_DIS]
                | (tone_in[c].nb_rin & ~s_r.ctrl2[c][`C2_NB_DIS]);
            ec_ctrl[c].ringing_suppress_enable = s_r.ctrl2[c][`C2_RING_EN];
            ec_ctrl[c].dc_removal_disable = s_r.ctrl2[c][`C2_DC_DIS];
            ec_ctrl[c].pad_rin = s_r.ctrl1[c][`C1_RX_PAD_LEGACY] ? `PAD_MINUS_12
                : s_r.gains[c][`G_RIN +: 3];
            ec_ctrl[c].pad_rout = s_r.gains[c][`G_ROUT +: 3];
            ec_ctrl[c].pad_sin = s_r.gains[c][`G_SIN +: 3];
            ec_ctrl[c].pad_sout = s_r.gains[c][`G_SOUT +: 3];
        end
    end

    // ======================================================================
    // next state
    logic [1:0] evt;
    logic [1:0] clr;
    logic [1:0] fire;
    logic present;
    logic rev;
    logic [9:0] need;
    logic [15:0] rin_m;

    always_comb begin
        s_nxt = s_r;
        evt = 2'h0;
        clr = 2'h0;
        fire = 2'h0;
        present = 1'b0;
        rev = 1'b0;
        need = `PLAIN_TONE_MS;
        rin_m = 16'h0000;

        // millisecond enable
        s_nxt.tick = 1'b0;
        if (s_r.div == 17'(CLKS_PER_MS - 1)) begin
            s_nxt.div = 17'h0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div = s_r.div + 17'h1;
        end

        // tone detectors: index 2*c is receive input, 2*c+1 send input
        for (int c = 0; c < 2; c++) begin
            need = s_r.ctrl2[c][`C2_PHASE_DIS] ? `PLAIN_TONE_MS
                : `PHASE_TONE_MS;
            for (int k = 0; k < 2; k++) begin
                present = (k == 0) ? tone_in[c].tone_rin : tone_in[c].tone_sin;
                rev = (k == 0) ? tone_in[c].rev_rin : tone_in[c].rev_sin;
                if (s_r.td[c] || !present) begin
                    // any gap in the tone restarts the duration count
                    s_nxt.tone_ms[c * 2 + k] = 10'h0;
                    s_nxt.rev_seen[c * 2 + k] = 1'b0;
                end else begin
                    if (rev) begin
                        s_nxt.rev_seen[c * 2 + k] = 1'b1;
                    end
                    if (s_r.tick && s_r.tone_ms[c * 2 + k] < need) begin
                        s_nxt.tone_ms[c * 2 + k] = s_r.tone_ms[c * 2 + k] + 10'h1;
                    end
                    if (s_r.tone_ms[c * 2 + k] >= need
                        && (s_r.ctrl2[c][`C2_PHASE_DIS] || s_r.rev_seen[c * 2 + k]))
                    begin
                        fire[c] = 1'b1;
                    end
                end
            end
            if (!s_r.td[c]) begin
                s_nxt.quiet_ms[c] = 9'h0;
                if (fire[c]) begin
                    s_nxt.td[c] = 1'b1;
                    evt[c] = 1'b1;
                end
            end else if (tone_in[c].quiet_rin && tone_in[c].quiet_sin) begin
                if (s_r.quiet_ms[c] == `RELEASE_MS) begin
                    s_nxt.td[c] = 1'b0;
                    s_nxt.quiet_ms[c] = 9'h0;
                    evt[c] = 1'b1;
                end else if (s_r.tick) begin
                    s_nxt.quiet_ms[c] = s_r.quiet_ms[c] + 9'h1;
                end
            end else begin
                s_nxt.quiet_ms[c] = 9'h0;
            end
        end

        // apb: read data and error captured in setup, access lasts one cycle
        if (setup) begin
            s_nxt.prdata = 32'h0;
            s_nxt.pslverr = ~mapped;
            if (idx == `IDX_CODING) begin
                s_nxt.prdata = {30'h0, s_r.coding};
            end else if (in_ch) begin
                case (off)
                    `IDX_CTRL1: s_nxt.prdata = {24'h0, s_r.ctrl1[ch]};
                    `IDX_CTRL2: s_nxt.prdata = {24'h0, s_r.ctrl2[ch]};
                    `IDX_STATUS: s_nxt.prdata = {30'h0, s_r.pend[ch], s_r.td[ch]};
                    `IDX_GAINS: s_nxt.prdata = {16'h0, s_r.gains[ch]};
                    default: s_nxt.prdata = 32'h0;
                endcase
            end
        end
        if (access && mapped) begin
            if (pwrite) begin
                if (idx == `IDX_CODING) begin
                    s_nxt.coding = coding_e'(pwdata[1:0]);
                end else if (off == `IDX_CTRL1) begin
                    s_nxt.ctrl1[ch] = pwdata[7:0];
                end else if (off == `IDX_CTRL2) begin
                    s_nxt.ctrl2[ch] = pwdata[7:0];
                end else if (off == `IDX_GAINS) begin
                    s_nxt.gains[ch] = pwdata[15:0];
                end
            end else if (in_ch && off == `IDX_STATUS) begin
                clr[ch] = 1'b1;
            end
        end
        // an event in the clearing cycle survives
        s_nxt.pend = (s_r.pend & ~clr) | evt;

        // pcm path
        s_nxt.pcm_valid = pcm_in_valid;
        if (pcm_in_valid) begin
            for (int c = 0; c < 2; c++) begin
                rin_m = s_r.ctrl2[c][`C2_RX_MUTE] ? quiet : pcm_in[c].rin;
                s_nxt.pcm[c].rin_ref = rin_m;
                // mute outranks bypass; bypass itself passes samples untouched
                s_nxt.pcm[c].rout = rin_m;
                s_nxt.pcm[c].sout = s_r.ctrl2[c][`C2_TX_MUTE] ? quiet
                    : pcm_in[c].sin;
                if (c == 1 && cfg != cfg_normal) begin
                    // second slot idles on the quiet code whatever its mute bits
                    s_nxt.pcm[c].rout = quiet;
                    s_nxt.pcm[c].sout = quiet;
                    s_nxt.pcm[c].rin_ref = quiet;
                end
            end
        end
    end

    // ======================================================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.ctrl1 <= {`CTRL1_RST, `CTRL1_RST};
            s_r.ctrl2 <= {`CTRL2_RST, `CTRL2_RST};
            s_r.gains <= {`GAINS_RST, `GAINS_RST};
            s_r.coding <= code_linear;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ======================================================================
    // outputs
    assign prdata = s_r.prdata;
    assign pready = access;
    assign pslverr = access & s_r.pslverr;
    assign pcm_out = s_r.pcm;
    assign pcm_out_valid = s_r.pcm_valid;
    assign group_cfg = cfg;
    assign tone_detected_flag = s_r.td;
    assign irq_n = ~|s_r.pend;

endmodule : ec_group_ctrl

// [ec_group_regs.svh]
// register indices, field positions, reset values and timing counts of the
// echo canceller group control block; assumes 32-bit apb, byte address = 4 * index
`ifndef EC_GROUP_REGS_SVH
`define EC_GROUP_REGS_SVH

// ==========================================================================
// register indices (first canceller; second canceller adds `IDX_B_BASE)
`define IDX_CTRL1 5'h00
`define IDX_CTRL2 5'h01
`define IDX_STATUS 5'h02
`define IDX_GAINS 5'h1c
`define IDX_B_BASE 8'h20
`define IDX_CODING 8'h40

// ==========================================================================
// control register one fields
`define C1_EXT_TAIL 0
`define C1_ADAPT_DIS 1
`define C1_BYPASS 2
`define C1_BACK_TO_BACK 3
`define C1_RX_PAD_LEGACY 4
// control register two fields
`define C2_PHASE_DIS 0
`define C2_AUTO_BYPASS 1
`define C2_NB_DIS 2
`define C2_DC_DIS 3
`define C2_RX_MUTE 4
`define C2_TX_MUTE 5
`define C2_RING_EN 6
// status fields
`define ST_TONE 0
`define ST_EVENT 1
// gains: 3-bit pad codes, 0 = +9 db ... 7 = -12 db
`define G_RIN 0
`define G_ROUT 4
`define G_SIN 8
`define G_SOUT 12
`define PAD_MINUS_12 3'h7

// ==========================================================================
// reset values
`define CTRL1_RST 8'h00
`define CTRL2_RST 8'h00
`define GAINS_RST 16'h0000

// ==========================================================================
// quiet codes
`define QUIET_LINEAR 16'h0000
`define QUIET_SIGN_MAG 16'h0080
`define QUIET_MULAW 16'h00ff
`define QUIET_ALAW 16'h00d5

// ==========================================================================
// timing, in milliseconds and clock figures
`define CLK_NS 8
`define MS_NS 1000000
`define PHASE_TONE_MS 10'd1000
`define PLAIN_TONE_MS 10'd400
`define RELEASE_MS 9'd400

`endif

// [ec_group_pkg.sv]
// types shared by the echo canceller group control block
// assumes nothing beyond a systemverilog tool
package ec_group_pkg;

    typedef enum logic [1:0] {
        cfg_normal = 2'b00,
        cfg_back_to_back = 2'b01,
        cfg_extended = 2'b10
    } cfg_e;

    typedef enum logic [1:0] {
        code_linear = 2'b00,
        code_sign_mag = 2'b01,
        code_mulaw = 2'b10,
        code_alaw = 2'b11
    } coding_e;

    typedef struct packed {
        logic tone_rin;
        logic tone_sin;
        logic rev_rin;
        logic rev_sin;
        logic quiet_rin;
        logic quiet_sin;
        logic nb_rin;
    } tone_in_s;

    typedef struct packed {
        logic [15:0] rin;
        logic [15:0] sin;
    } pcm_s;

    typedef struct packed {
        logic [15:0] rout;
        logic [15:0] sout;
        logic [15:0] rin_ref;
    } pcm_out_s;

    typedef struct packed {
        logic bypass;
        logic coef_clear;
        logic adapt_halt;
        logic ringing_suppress_enable;
        logic dc_removal_disable;
        logic [2:0] pad_rin;
        logic [2:0] pad_rout;
        logic [2:0] pad_sin;
        logic [2:0] pad_sout;
    } ec_ctrl_s;

    typedef struct packed {
        logic [1:0][7:0] ctrl1;
        logic [1:0][7:0] ctrl2;
        logic [1:0][15:0] gains;
        coding_e coding;
        logic [16:0] div;
        logic tick;
        logic [3:0][9:0] tone_ms;
        logic [3:0] rev_seen;
        logic [1:0] td;
        logic [1:0][8:0] quiet_ms;
        logic [1:0] pend;
        pcm_out_s [1:0] pcm;
        logic pcm_valid;
        logic [31:0] prdata;
        logic pslverr;
    } state_s;

endpackage : ec_group_pkg

// [ec_group_ctrl_chk.sv]
// port checker for the echo canceller group control block
// assumes it is bound into ec_group_ctrl and sees only its ports
`timescale 1ns/1ns
module ec_group_ctrl_chk #(
    parameter int CLKS_PER_MS = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire ec_group_pkg::tone_in_s [1:0] tone_in,
    input wire logic pcm_in_valid,
    input wire ec_group_pkg::pcm_out_s [1:0] pcm_out,
    input wire logic pcm_out_valid,
    input wire ec_group_pkg::ec_ctrl_s [1:0] ec_ctrl,
    input wire ec_group_pkg::cfg_e group_cfg,
    input wire logic [1:0] tone_detected_flag,
    input wire logic irq_n
);
    import ec_group_pkg::*;
    // ========================================================================
    // run lengths of tone and of calm on the first canceller
    logic [19:0] run_r;
    logic [19:0] calm_r;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_r <= '0;
            calm_r <= '0;
        end else begin
            run_r <= (tone_in[0].tone_rin || tone_in[0].tone_sin) ? run_r + 20'h1 : '0;
            calm_r <= (tone_in[0].quiet_rin && tone_in[0].quiet_sin) ? calm_r + 20'h1 : '0;
        end
    end
    // ========================================================================
    // assertions
    AST_ZERO_WAIT: assert property (psel && penable |-> pready) else $error("access stalled");
    AST_ERR_ACCESS: assert property (pslverr |-> psel && penable) else $error("stray slave error");
    AST_DET_TIME: assert property ($rose(tone_detected_flag[0]) |-> run_r >= 399 * CLKS_PER_MS - 1)
        else $error("tone detected too early");
    AST_IRQ_DET: assert property ($rose(tone_detected_flag[0]) || $rose(tone_detected_flag[1])
        |-> !irq_n) else $error("no interrupt on detection");
    AST_FLAG_HOLD: assert property (tone_detected_flag[0] &&
        !(tone_in[0].quiet_rin && tone_in[0].quiet_sin) |=> tone_detected_flag[0])
        else $error("flag dropped without calm");
    AST_REL_TIME: assert property ($fell(tone_detected_flag[0]) |-> calm_r >= 399 * CLKS_PER_MS - 1)
        else $error("release too early");
    AST_IRQ_REL: assert property ($fell(tone_detected_flag[0]) || $fell(tone_detected_flag[1])
        |-> !irq_n) else $error("no interrupt on release");
    AST_SLOT1_QUIET: assert property (group_cfg != cfg_normal && pcm_in_valid
        |=> pcm_out_valid && pcm_out[1].rout == pcm_out[1].sout) else $error("second slot not quiet");
    AST_BYPASS_CLEAR: assert property (ec_ctrl[0].coef_clear == ec_ctrl[0].bypass &&
        ec_ctrl[1].coef_clear == ec_ctrl[1].bypass) else $error("bypass without clearing");
    AST_PCM_VALID: assert property (1'b1 |=> pcm_out_valid == $past(pcm_in_valid))
        else $error("output strobe misplaced");
endmodule : ec_group_ctrl_chk

bind ec_group_ctrl ec_group_ctrl_chk #(.CLKS_PER_MS(CLKS_PER_MS)) u_chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .tone_in(tone_in), .pcm_in_valid(pcm_in_valid), .pcm_out(pcm_out),
    .pcm_out_valid(pcm_out_valid), .ec_ctrl(ec_ctrl), .group_cfg(group_cfg),
    .tone_detected_flag(tone_detected_flag), .irq_n(irq_n)
);

// [pcm_line.sv]
// model of the pcm time slot streams feeding one canceller group
// assumes one sample pair per four clocks while run is high
`timescale 1ns/1ns
module pcm_line (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    output ec_group_pkg::pcm_s [1:0] pcm_in,
    output logic pcm_in_valid
);
    import ec_group_pkg::*;
    integer seed;
    logic [1:0] ph;
    initial begin
        seed = 32'h4093;
        ph = 2'h0;
        pcm_in = '0;
        pcm_in_valid = 1'b0;
    end
    // between slots the lines toggle between the inverse and the sample every clock, so a stale sample never passes
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ph <= 2'h0;
            pcm_in_valid <= 1'b0;
        end else begin
            ph <= ph + 2'h1;
            pcm_in_valid <= run && ph == 2'h0;
            if (run && ph == 2'h0) pcm_in <= {$random(seed), $random(seed)};
            else pcm_in <= ~pcm_in;
        end
    end
endmodule : pcm_line

// [tb.sv]
// self-checking bench for the echo canceller group control block
// assumes a shortened millisecond of ten clocks
`timescale 1ns/1ns
module tb;
    import ec_group_pkg::*;
    localparam logic [11:0] C1A = 12'h000, C2A = 12'h004, STA = 12'h008, GNA = 12'h070;
    localparam logic [11:0] C1B = 12'h080, C2B = 12'h084, STB = 12'h088, CODE = 12'h100;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    tone_in_s [1:0] tone_in = '0;
    pcm_s [1:0] pcm_in;
    logic pcm_in_valid;
    logic pcm_run = 1'b0;
    pcm_out_s [1:0] pcm_out;
    logic pcm_out_valid;
    ec_ctrl_s [1:0] ec_ctrl;
    cfg_e group_cfg;
    logic [1:0] tone_detected_flag;
    logic irq_n;
    int n_mismatch = 0;
    int n_compared = 0;
    int n;
    logic [31:0] q;
    logic err;
    logic [95:0] e;
    logic [31:0] mdl [logic [11:0]];
    logic [95:0] exp_q [$];
    logic [11:0] regs [7] = '{C1A, C2A, STA, GNA, C1B, C2B, CODE};
    logic [39:0] rows [5] = '{40'h0000100000, 40'h0800201001, 40'h0100100002,
        40'h0808200003, 40'h0908300000};

    always #4 clk = ~clk;

    ec_group_ctrl #(.CLKS_PER_MS(10)) DUT (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tone_in(tone_in), .pcm_in(pcm_in),
        .pcm_in_valid(pcm_in_valid), .pcm_out(pcm_out), .pcm_out_valid(pcm_out_valid),
        .ec_ctrl(ec_ctrl), .group_cfg(group_cfg), .tone_detected_flag(tone_detected_flag),
        .irq_n(irq_n));
    pcm_line u_line (.clk(clk), .rst(rst), .run(pcm_run), .pcm_in(pcm_in),
        .pcm_in_valid(pcm_in_valid));

    // ========================================================================
    // tasks and model
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [47:0] seen, input logic [47:0] want);
        n_compared++;
        if (seen !== want) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) n_mismatch++;
        q = prdata;
        err = pslverr;
        if (w) mdl[a] = d;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [31:0] m(input logic [11:0] a);
        return mdl.exists(a) ? mdl[a] : 32'h0;
    endfunction : m
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] want);
        apb(1'b0, a, 32'h0);
        chk({err, q}, {1'b0, want});
    endtask : rd
    task automatic waitf(input int c, input logic v);
        n = 0;
        while (tone_detected_flag[c] !== v && n < 12000) begin
            @(negedge clk);
            n++;
        end
    endtask : waitf
    function automatic logic [47:0] slot(input logic [31:0] in, input logic [31:0] c2,
        input logic [15:0] qc);
        logic [15:0] r;
        r = c2[4] ? qc : in[31:16];
        return {r, c2[5] ? qc : in[15:0], r};
    endfunction : slot
    function automatic logic [95:0] expect_pcm();
        logic [15:0] qc;
        logic [31:0] c1a;
        logic [31:0] c1b;
        c1a = m(C1A);
        c1b = m(C1B);
        case (m(CODE) & 3)
            0: qc = 16'h0000;
            1: qc = 16'h0080;
            2: qc = 16'h00ff;
            default: qc = 16'h00d5;
        endcase
        if ((c1a[3] && c1b[3]) || c1a[0]) return {qc, qc, 16'h0, slot(pcm_in[0], m(C2A), qc)};
        return {slot(pcm_in[1], m(C2B), qc), slot(pcm_in[0], m(C2A), qc)};
    endfunction : expect_pcm
    always @(posedge clk) begin
        if (pcm_out_valid === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk(pcm_out[0], e[47:0]);
            chk(pcm_out[1][47:16], e[95:64]);
        end
        if (pcm_in_valid === 1'b1) exp_q.push_back(expect_pcm());
    end

    // ========================================================================
    // watchdog and main sequence
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (regs[i]) rd(regs[i], 32'h0);
        wr(C2B, 32'h7f);
        rd(C2B, m(C2B));
        apb(1'b1, 12'h104, 32'h5);
        chk({err, q}, 33'h100000000);
        // address bits above the index are not decoded; probe a hole in the map
        apb(1'b0, 12'h00c, 32'h0);
        chk({err, q}, 33'h100000000);
        wr(GNA, 32'h4321);
        @(negedge clk);
        chk({ec_ctrl[0].pad_rin, ec_ctrl[0].pad_rout, ec_ctrl[0].pad_sin, ec_ctrl[0].pad_sout},
            {3'd1, 3'd2, 3'd3, 3'd4});
        wr(C1A, 32'h10);
        @(negedge clk);
        chk({ec_ctrl[0].pad_rin, ec_ctrl[0].pad_rout}, {3'h7, 3'd2});
        wr(GNA, 32'h0);
        wr(C2A, 32'h48);
        @(posedge clk) tone_in[0].nb_rin <= 1'b1;
        @(negedge clk);
        chk({ec_ctrl[0].ringing_suppress_enable, ec_ctrl[0].dc_removal_disable,
            ec_ctrl[0].adapt_halt}, 3'b111);
        wr(C2A, 32'h04);
        @(negedge clk);
        chk(ec_ctrl[0].adapt_halt, 1'b0);
        @(posedge clk) tone_in[0].nb_rin <= 1'b0;
        foreach (rows[i]) begin
            wr(C1A, rows[i][39:32]);
            wr(C1B, rows[i][31:24]);
            wr(C2A, rows[i][23:16]);
            wr(C2B, rows[i][15:8]);
            wr(CODE, rows[i][7:0]);
            @(negedge clk);
            chk(group_cfg, rows[i][35] && rows[i][27] ? cfg_back_to_back :
                rows[i][32] ? cfg_extended : cfg_normal);
            @(posedge clk) pcm_run <= 1'b1;
            repeat (40) @(posedge clk);
            pcm_run <= 1'b0;
            repeat (8) @(posedge clk);
        end
        chk(exp_q.size(), 0);
        wr(C1A, 32'h0);
        wr(C1B, 32'h0);
        wr(C2A, 32'h03);
        @(posedge clk) tone_in[0].tone_rin <= 1'b1;
        waitf(0, 1'b1);
        chk(n >= 3990 && n <= 4010, 1'b1);
        chk({irq_n, ec_ctrl[0].bypass}, 2'b01);
        @(posedge clk) tone_in[0].tone_rin <= 1'b0;
        repeat (500) @(posedge clk);
        rd(STA, 32'h3);
        @(negedge clk);
        chk(irq_n, 1'b1);
        @(posedge clk) tone_in[0].quiet_rin <= 1'b1;
        repeat (4500) @(posedge clk);
        @(negedge clk);
        chk(tone_detected_flag[0], 1'b1);
        @(posedge clk) tone_in[0].quiet_sin <= 1'b1;
        waitf(0, 1'b0);
        chk(n >= 3990 && n <= 4010, 1'b1);
        chk({irq_n, ec_ctrl[0].bypass}, 2'b00);
        rd(STA, 32'h2);
        @(posedge clk) tone_in[1].tone_sin <= 1'b1;
        repeat (100) @(posedge clk);
        tone_in[1].rev_sin <= 1'b1;
        @(posedge clk) tone_in[1].rev_sin <= 1'b0;
        waitf(1, 1'b1);
        chk(n >= 9880 && n <= 9915, 1'b1);
        chk({irq_n, ec_ctrl[1].bypass}, 2'b00);
        wr(C1B, 32'h4);
        @(negedge clk);
        chk({ec_ctrl[1].bypass, ec_ctrl[1].coef_clear}, 2'b11);
        repeat (20) @(posedge clk);
        rd(STB, 32'h3);
        report_and_stop();
    end
endmodule : tb
